// ---- src/ecd_consts.svh ----
// Offsets, field positions, reset values and timing counts
`ifndef ECD_CONSTS_SVH
`define ECD_CONSTS_SVH

// Register indices; byte address is four times the index
`define ECD_IDX_CLK_CTRL 8'h25
`define ECD_IDX_OPERATING_MODE_FIELD 8'h26
`define ECD_IDX_CHAN_EN 8'h27
`define ECD_IDX_STATUS 8'h28
`define ECD_ADDR_CLK_CTRL (`ECD_IDX_CLK_CTRL << 2)
`define ECD_ADDR_OPERATING_MODE_FIELD (`ECD_IDX_OPERATING_MODE_FIELD << 2)
`define ECD_ADDR_CHAN_EN (`ECD_IDX_CHAN_EN << 2)
`define ECD_ADDR_STATUS (`ECD_IDX_STATUS << 2)
`define ECD_REG_RESET 8'h00

// Field positions
`define ECD_SRC_LSB 0
`define ECD_SRC_MSB 1
`define ECD_DIV_LSB 4
`define ECD_DIV_MSB 7
`define ECD_MODE_LSB 0
`define ECD_MODE_MSB 3
`define ECD_CHAN_LSB 4
`define ECD_CHAN_MSB 7

// Source field codes
`define ECD_SRC_INTERNAL 2'h0
`define ECD_SRC_MCLK 2'h1
`define ECD_SRC_BCLK 2'h2

// Operating mode codes
`define ECD_MODE_STANDBY 4'h0
`define ECD_MODE_HEART 4'h1
`define ECD_MODE_ULTRA_LOW 4'h2
`define ECD_MODE_VERY_LOW 4'h3

// Divider codes and ratios
`define ECD_DIV_CODE_MAX 4'h8
`define ECD_RATIO_0 5'h01
`define ECD_RATIO_1 5'h02
`define ECD_RATIO_2 5'h03
`define ECD_RATIO_3 5'h04
`define ECD_RATIO_4 5'h06
`define ECD_RATIO_5 5'h08
`define ECD_RATIO_6 5'h0C
`define ECD_RATIO_7 5'h10
`define ECD_RATIO_8 5'h18

// Timing: internal oscillator emulated by a phase accumulator
`define ECD_CLOCK_PERIOD_NS 20
`define ECD_CLOCK_KHZ (1000000 / `ECD_CLOCK_PERIOD_NS)
`define ECD_NOMINAL_KHZ 1024
`define ECD_ACC_INC 17'(`ECD_NOMINAL_KHZ)
`define ECD_ACC_MOD 17'(`ECD_CLOCK_KHZ)

`endif

// ---- src/ecd_pkg.sv ----
// Types and divider decode for the external clock divider block
`default_nettype none
`include "ecd_consts.svh"

package ecd_pkg;
    typedef logic [7:0] ecd_byte_type;
    typedef logic [4:0] ecd_ratio_type;

    function automatic ecd_ratio_type ecd_decode_ratio(
        input logic [3:0] code
    );
        ecd_ratio_type r;
        r = `ECD_RATIO_0;
        case (code)
            4'h0: r = `ECD_RATIO_0;
            4'h1: r = `ECD_RATIO_1;
            4'h2: r = `ECD_RATIO_2;
            4'h3: r = `ECD_RATIO_3;
            4'h4: r = `ECD_RATIO_4;
            4'h5: r = `ECD_RATIO_5;
            4'h6: r = `ECD_RATIO_6;
            4'h7: r = `ECD_RATIO_7;
            4'h8: r = `ECD_RATIO_8;
            // Reserved codes fall back to no division
            default: r = `ECD_RATIO_0;
        endcase
        return r;
    endfunction : ecd_decode_ratio
endpackage : ecd_pkg

`default_nettype wire

// ---- src/ecd_div_if.sv ----
// Link between the clock selector and its edge divider
`default_nettype none

interface ecd_div_if;
    import ecd_pkg::*;
    logic edgePulse;
    logic restart;
    ecd_ratio_type ratio;
    logic tick;

    modport ctl (output edgePulse, output restart, output ratio,
        input tick);
    modport div (input edgePulse, input restart, input ratio,
        output tick);
endinterface : ecd_div_if

`default_nettype wire

// ---- src/ecd_edge_divider.sv ----
// Integer divider counting edges of the selected external clock
`default_nettype none

module ecd_edge_divider (
    input wire logic clock,
    input wire logic sys_rst,
    ecd_div_if.div link
);
    import ecd_pkg::*;

    ecd_ratio_type count;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (sys_rst || link.restart)
        begin
            count <= 5'h00;
        end
        else if (link.edgePulse)
        begin
            if (count >= link.ratio - 5'h01)
            begin
                count <= 5'h00;
            end
            else
            begin
                count <= count + 5'h01;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || link.restart)
        begin
            link.tick <= 1'b0;
        end
        else
        begin
            // One tick per ratio edges
            link.tick <= link.edgePulse && (count >= link.ratio - 5'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_div_tick_cause: assert property (@(posedge clock)
        disable iff (sys_rst)
        link.tick |-> $past(link.edgePulse) && !$past(link.restart)
            && ($past(count) == $past(link.ratio) - 5'h01))
        else $error("divider tick without its terminal edge");

    a_div_count_bound: assert property (@(posedge clock)
        disable iff (sys_rst)
        count < 5'h18)
        else $error("divider count beyond largest ratio");
endmodule : ecd_edge_divider

`default_nettype wire

// ---- src/ecd_clock_select.sv ----
// Clock source selection, external clock division and register file
//
// Contract
// - Device accepts external clock on master or bit clock pin.
// - Device divides external clock by ratio in divider field.
// - Codes 0 to 8 map to ratios 1,2,3,4,6,8,12,16,24.
// - Divided clock is 1024 kHz or 256 kHz, set by mode; code only raises lowRateMode, tick rate not changed.
// - Clock control of zero selects internal clock, no division.
`default_nettype none
`include "ecd_consts.svh"

module ecd_clock_select (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mclkPin,
    input wire logic bclkPin,
    output logic sysClkTick,
    output logic [1:0] activeSource,
    output logic lowRateMode,
    output logic [3:0] channelEnable,
    output logic [3:0] operatingMode
);
    import ecd_pkg::*;

    ecd_byte_type clockSourceControl;
    ecd_byte_type operatingModeReg;
    ecd_byte_type channelEnableReg;
    logic mclkPrev;
    logic bclkPrev;
    logic [16:0] phaseAcc;
    logic internalTick;
    logic [1:0] prevSource;
    ecd_ratio_type prevRatio;
    logic accessDone;
    logic addrHit;
    logic [1:0] clockSourceSelect;
    logic [3:0] extDividerSelect;
    logic [3:0] operatingModeField;
    logic useMclk;
    logic useBclk;
    logic modeIsLow;
    ecd_ratio_type effRatio;
    ecd_byte_type statusByte;
    ecd_byte_type readByte;

    ecd_div_if divLink ();

    ecd_edge_divider u_divider (
        .clock(clock),
        .sys_rst(sys_rst),
        .link(divLink)
    );

    ////////////////////////////////////////////////////////////////////
    // Field decode
    assign clockSourceSelect =
        clockSourceControl[`ECD_SRC_MSB:`ECD_SRC_LSB];
    assign extDividerSelect =
        clockSourceControl[`ECD_DIV_MSB:`ECD_DIV_LSB];
    assign operatingModeField =
        operatingModeReg[`ECD_MODE_MSB:`ECD_MODE_LSB];
    assign useMclk = (clockSourceSelect == `ECD_SRC_MCLK);
    // Code 10 picks the bit clock pin; 11 is treated as internal
    assign useBclk = (clockSourceSelect == `ECD_SRC_BCLK);
    assign effRatio = ecd_decode_ratio(extDividerSelect);
    assign modeIsLow = (operatingModeField == `ECD_MODE_HEART)
        || (operatingModeField == `ECD_MODE_ULTRA_LOW)
        || (operatingModeField == `ECD_MODE_VERY_LOW);

    ////////////////////////////////////////////////////////////////////
    // External edges; pins are synchronous so one flop finds the edge
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            mclkPrev <= 1'b0;
            bclkPrev <= 1'b0;
        end
        else
        begin
            mclkPrev <= mclkPin;
            bclkPrev <= bclkPin;
        end
    end

    assign divLink.edgePulse = useMclk ? (mclkPin && !mclkPrev) :
        useBclk ? (bclkPin && !bclkPrev) : 1'b0;
    assign divLink.ratio = effRatio;
    // Restart on any change so a stale count never shortens a period
    assign divLink.restart = (prevSource != clockSourceSelect)
        || (prevRatio != effRatio);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prevSource <= `ECD_SRC_INTERNAL;
            prevRatio <= `ECD_RATIO_0;
        end
        else
        begin
            prevSource <= clockSourceSelect;
            prevRatio <= effRatio;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal oscillator stand-in: fractional accumulator, jitter of
    // one system clock period traded for an exact long-term rate
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            phaseAcc <= 17'h00000;
            internalTick <= 1'b0;
        end
        else if (phaseAcc + `ECD_ACC_INC >= `ECD_ACC_MOD)
        begin
            phaseAcc <= phaseAcc + `ECD_ACC_INC - `ECD_ACC_MOD;
            internalTick <= 1'b1;
        end
        else
        begin
            phaseAcc <= phaseAcc + `ECD_ACC_INC;
            internalTick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock outputs
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sysClkTick <= 1'b0;
            activeSource <= `ECD_SRC_INTERNAL;
            lowRateMode <= 1'b0;
        end
        else
        begin
            // Zero in clock control lands here: internal, undivided
            sysClkTick <= (useMclk || useBclk) ? divLink.tick
                : internalTick;
            activeSource <= (useMclk || useBclk) ? clockSourceSelect
                : `ECD_SRC_INTERNAL;
            lowRateMode <= modeIsLow;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, every answer registered
    assign accessDone = psel && penable && pready;
    assign addrHit = (paddr == `ECD_ADDR_CLK_CTRL)
        || (paddr == `ECD_ADDR_OPERATING_MODE_FIELD)
        || (paddr == `ECD_ADDR_CHAN_EN)
        || (paddr == `ECD_ADDR_STATUS);
    assign statusByte = {3'h0, (effRatio == `ECD_RATIO_0)
        && (extDividerSelect != 4'h0), operatingModeField != 4'h0,
        modeIsLow, activeSource};

    always_comb
    begin
        readByte = 8'h00;
        case (paddr)
            `ECD_ADDR_CLK_CTRL: readByte = clockSourceControl;
            `ECD_ADDR_OPERATING_MODE_FIELD: readByte = operatingModeReg;
            `ECD_ADDR_CHAN_EN: readByte = channelEnableReg;
            `ECD_ADDR_STATUS: readByte = statusByte;
            default: readByte = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addrHit;
            prdata <= (psel && penable && !pready && !pwrite)
                ? {24'h000000, readByte} : 32'h00000000;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clockSourceControl <= `ECD_REG_RESET;
            operatingModeReg <= `ECD_REG_RESET;
            channelEnableReg <= `ECD_REG_RESET;
        end
        else if (accessDone && pwrite)
        begin
            if (paddr == `ECD_ADDR_CLK_CTRL)
            begin
                clockSourceControl <= pwdata[7:0];
            end
            if (paddr == `ECD_ADDR_OPERATING_MODE_FIELD)
            begin
                operatingModeReg <= pwdata[7:0];
            end
            if (paddr == `ECD_ADDR_CHAN_EN)
            begin
                channelEnableReg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            channelEnable <= 4'h0;
            operatingMode <= 4'h0;
        end
        else
        begin
            channelEnable <=
                channelEnableReg[`ECD_CHAN_MSB:`ECD_CHAN_LSB];
            operatingMode <= operatingModeField;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_setup_write_ctrl;
        psel && !penable && pwrite && (paddr == `ECD_ADDR_CLK_CTRL);
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    a_ctrl_write_lands: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_setup_write_ctrl ##1 (psel && penable && !pready)
            ##1 s_access_done
        |=> clockSourceControl == $past(pwdata[7:0]))
        else $error("clock control write did not land");

    a_apb_one_wait: assert property (@(posedge clock)
        disable iff (sys_rst)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("access phase length is not two cycles");

    a_unmapped_error: assert property (@(posedge clock)
        disable iff (sys_rst)
        pready |-> pslverr == !$past(addrHit))
        else $error("unmapped address answered without error");

    a_zero_internal: assert property (@(posedge clock)
        disable iff (sys_rst)
        clockSourceControl == 8'h00 ##1 clockSourceControl == 8'h00
        |-> activeSource == `ECD_SRC_INTERNAL
            && sysClkTick == $past(internalTick))
        else $error("zero control did not give undivided internal clock");

    a_reserved_code: assert property (@(posedge clock)
        disable iff (sys_rst)
        extDividerSelect > `ECD_DIV_CODE_MAX |-> effRatio == `ECD_RATIO_0)
        else $error("reserved divider code not undivided");

    a_ratio_largest: assert property (@(posedge clock)
        disable iff (sys_rst)
        extDividerSelect == 4'h8 |-> effRatio == 5'h18)
        else $error("largest divider code not twenty four");

    a_mclk_follows: assert property (@(posedge clock)
        disable iff (sys_rst)
        useMclk && $stable(clockSourceControl) ##1 useMclk
        |-> sysClkTick == $past(divLink.tick))
        else $error("master clock pin not driving system tick");

    a_tick_spaced: assert property (@(posedge clock)
        disable iff (sys_rst)
        sysClkTick |=> !sysClkTick)
        else $error("system tick held for two cycles");

    a_low_rate_flag: assert property (@(posedge clock)
        disable iff (sys_rst)
        operatingModeField == `ECD_MODE_HEART |=> lowRateMode)
        else $error("heart sound mode not flagged low rate");
endmodule : ecd_clock_select

`default_nettype wire

// ---- sim/ecd_ext_clock_model.sv ----
// Partner model: external reference clock driven onto one pin
`default_nettype none

module ecd_ext_clock_model #(
    parameter int HALF = 2
) (
    input wire logic clock,
    input wire logic run,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;

    // Whole pin periods only, so any ratio divides exactly
    always_ff @(posedge clock)
    begin
        if (!run)
        begin
            cnt <= 0;
            // Stands still low while unused, never free-running
            pin <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            pin <= ~pin;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
endmodule : ecd_ext_clock_model

`default_nettype wire

// ---- sim/external_clock_divider_select_bench.sv ----
// Self-checking bench for the clock selector and divider
`default_nettype none
`include "ecd_consts.svh"

module external_clock_divider_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, sys_rst, psel, penable, pwrite, mclkPin, bclkPin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sysClkTick, lowRateMode, err, mclkRun, bclkRun;
    logic [1:0] activeSource;
    logic [3:0] channelEnable, operatingMode;
    int fails = 0;
    int compares = 0;
    int gap;
    int ratios[10] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 1};

    ecd_clock_select i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mclkPin(mclkPin), .bclkPin(bclkPin), .sysClkTick(sysClkTick),
        .activeSource(activeSource), .lowRateMode(lowRateMode),
        .channelEnable(channelEnable), .operatingMode(operatingMode));
    // Two sources at different rates expose counting of the wrong pin
    ecd_ext_clock_model #(.HALF(2)) i_mclk (.clock(clock), .run(mclkRun),
        .pin(mclkPin));
    ecd_ext_clock_model #(.HALF(3)) i_bclk (.clock(clock), .run(bclkRun),
        .pin(bclkPin));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            fails++;
    endtask : apb

    // Second gap only: the first may straddle a restart
    task tick_gap;
        int n;
        repeat (2)
        begin
            n = 0;
            gap = 0;
            @(negedge clock);
            while (sysClkTick !== 1'b1 && n < 3000)
            begin
                @(negedge clock);
                n++;
            end
            do
            begin
                @(negedge clock);
                gap++;
            end
            while (sysClkTick !== 1'b1 && gap < 3000);
        end
    endtask : tick_gap

    ////////////////////////////////////////////////////////////////////////
    task test_reset;
        @(negedge clock);
        check("source", 32'h0, 32'(activeSource));
        check("channels", 32'h0, 32'(channelEnable));
        apb(1'b0, `ECD_ADDR_CLK_CTRL, 8'h00);
        check("clock control", 32'h0, rd);
        apb(1'b0, `ECD_ADDR_OPERATING_MODE_FIELD, 8'h00);
        check("mode register", 32'h0, rd);
        apb(1'b0, `ECD_ADDR_CHAN_EN, 8'h00);
        check("channel register", 32'h0, rd);
    endtask : test_reset

    task test_regs;
        apb(1'b0, 8'h00, 8'h00);
        check("unmapped read err", 32'h1, 32'(err));
        check("unmapped read data", 32'h0, rd);
        apb(1'b1, 8'hFC, 8'h55);
        check("unmapped write err", 32'h1, 32'(err));
        apb(1'b1, `ECD_ADDR_CHAN_EN, 8'hA5);
        apb(1'b0, `ECD_ADDR_CHAN_EN, 8'h00);
        check("channel readback", 32'hA5, rd);
        repeat (3) @(negedge clock);
        check("channel out", 32'hA, 32'(channelEnable));
        apb(1'b1, `ECD_ADDR_CHAN_EN, 8'h00);
    endtask : test_regs

    // Mode stays zero while source and divider change
    task test_divider(input logic [1:0] src, input int period);
        for (int c = 0; c < 10; c++)
        begin
            apb(1'b1, `ECD_ADDR_CLK_CTRL, {4'(c), 2'b00, src});
            tick_gap();
            check("source", 32'(src), 32'(activeSource));
            check("divided gap", 32'(ratios[c] * period), 32'(gap));
            apb(1'b0, `ECD_ADDR_STATUS, 8'h00);
            check("status", 32'({c > 8, 2'b00, src}), rd);
        end
    endtask : test_divider

    task test_internal;
        apb(1'b1, `ECD_ADDR_CLK_CTRL, 8'h00);
        tick_gap();
        check("internal source", 32'h0, 32'(activeSource));
        check("internal gap", 32'h1, 32'(gap == 48 || gap == 49));
    endtask : test_internal

    task test_modes;
        apb(1'b1, `ECD_ADDR_CHAN_EN, 8'hF0);
        for (int m = 0; m < 5; m++)
        begin
            apb(1'b1, `ECD_ADDR_OPERATING_MODE_FIELD, 8'(m));
            repeat (3) @(negedge clock);
            check("mode out", 32'(m), 32'(operatingMode));
            check("low rate", 32'(m >= 1 && m <= 3), 32'(lowRateMode));
            apb(1'b0, `ECD_ADDR_STATUS, 8'h00);
            check("status", 32'({m != 0, m >= 1 && m <= 3, 2'b00}), rd);
        end
        apb(1'b1, `ECD_ADDR_OPERATING_MODE_FIELD, 8'h00);
    endtask : test_modes

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mclkRun = 1'b0;
        bclkRun = 1'b0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        test_reset();
        test_regs();
        mclkRun <= 1'b1;
        bclkRun <= 1'b1;
        test_divider(2'h1, 4);
        test_divider(2'h2, 6);
        // Pins stop first so no external tick lands beside an internal one
        @(posedge clock);
        mclkRun <= 1'b0;
        bclkRun <= 1'b0;
        test_internal();
        test_modes();
        report_and_stop();
    end

    initial
    begin
        #800000;
        fails++;
        report_and_stop();
    end
endmodule : external_clock_divider_select_bench

`default_nettype wire
